// ### gpio_kl_sc_ports.sv
// data registers of a bidirectional, an input-only and a serial-pin port behind APB
// assumes pin modes and the receive enable come from the pin-function and serial
// controllers, and pin inputs are synchronous to mclk
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_kl_sc_params.svh"

module gpio_kl_sc_ports (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pin modes from the pin-function controller and serial controller
   input wire gpio_kl_sc_pkg::byte_t bidirPinModeHi,
   input wire gpio_kl_sc_pkg::byte_t bidirPinModeLo,
   input wire gpio_kl_sc_pkg::byte_t inonlyPinModeHi,
   input wire gpio_kl_sc_pkg::byte_t inonlyPinModeLo,
   input wire gpio_kl_sc_pkg::byte_t serpinModeHi,
   input wire gpio_kl_sc_pkg::byte_t serpinModeLo,
   input wire logic receiveEnable,
   // bidirectional port pins
   input wire gpio_kl_sc_pkg::byte_t bidirPinIn,
   output gpio_kl_sc_pkg::byte_t bidirPinOut,
   output gpio_kl_sc_pkg::byte_t bidirPinOe,
   output gpio_kl_sc_pkg::byte_t bidirPullUp,
   // input-only port pins
   input wire gpio_kl_sc_pkg::byte_t inonlyPinIn,
   // serial-pin port pins
   input wire gpio_kl_sc_pkg::byte_t serpinIn,
   output gpio_kl_sc_pkg::byte_t serpinOut,
   output gpio_kl_sc_pkg::byte_t serpinOe,
   output gpio_kl_sc_pkg::byte_t serpinPullUp
);
   import gpio_kl_sc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // mode decoding

   function automatic pinMode_t modeOf(input logic hi, input logic lo);
      modeOf = pinMode_t'({hi, lo});
   endfunction : modeOf

   // mask of bits whose mode is either input setting
   function automatic byte_t inputMask(input byte_t hi, input byte_t lo);
      inputMask = '0;
      for (int i = 0; i < `PORT_WIDTH; i++) begin
         inputMask[i] = (modeOf(hi[i], lo[i]) == MODE_IN_PU) || (modeOf(hi[i], lo[i]) == MODE_IN_NOPU);
      end
   endfunction : inputMask

   function automatic byte_t modeMask(input byte_t hi, input byte_t lo, input pinMode_t m);
      modeMask = '0;
      for (int i = 0; i < `PORT_WIDTH; i++) begin
         modeMask[i] = (modeOf(hi[i], lo[i]) == m);
      end
   endfunction : modeMask

   ////////////////////////////////////////////////////////////////////////////
   // state

   byte_t bidir_r;
   byte_t inonly_r;
   logic [`SER_RW_MSB:0] serpin_r;
   logic setup;
   logic wrDone;
   logic hitBidir;
   logic hitInonly;
   logic hitSerpin;
   byte_t bidirIn;
   byte_t serIn;
   byte_t serRxForce;
   byte_t bidirRd;
   byte_t serpinRd;
   logic [31:0] prdata_nxt;

   assign setup = psel && !penable;
   assign wrDone = psel && penable && pready && pwrite;
   assign hitBidir = (paddr == `BIDIR_ADDR);
   assign hitInonly = (paddr == `INONLY_ADDR);
   assign hitSerpin = (paddr == `SERPIN_ADDR);
   assign bidirIn = inputMask(bidirPinModeHi, bidirPinModeLo);
   // receive enable overrides the port mode on the rx pins
   assign serRxForce = receiveEnable ? `SER_RX_MASK : 8'h00;
   assign serIn = inputMask(serpinModeHi, serpinModeLo) | serRxForce;

   ////////////////////////////////////////////////////////////////////////////
   // read values

   // stored bit in alternate or output mode, pin level in input modes
   assign bidirRd = (bidir_r & ~bidirIn) | (bidirPinIn & bidirIn);
   // bit 7 has no storage: pin level only when input, else low
   assign serpinRd = ({1'b0, serpin_r} & ~serIn) | (serpinIn & serIn);

   always_comb begin
      prdata_nxt = 32'h0000_0000;
      if (hitBidir) begin
         prdata_nxt[`PORT_WIDTH-1:0] = bidirRd;
      end else if (hitInonly) begin
         prdata_nxt[`PORT_WIDTH-1:0] = inonly_r;
      end else if (hitSerpin) begin
         prdata_nxt[`PORT_WIDTH-1:0] = serpinRd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer: no wait state, read data captured at the setup cycle

   always_ff @(posedge mclk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !(hitBidir || hitInonly || hitSerpin);
         prdata <= setup ? prdata_nxt : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data registers; power-on reset clears them, apb writes load bidir and serial, the input-only one follows its pins in input modes, else zero

   always_ff @(posedge mclk) begin
      if (srst) begin
         bidir_r <= `BIDIR_RST;
      end else if (wrDone && hitBidir) begin
         bidir_r <= pwdata[`PORT_WIDTH-1:0];
      end
   end

   // input-only port: writes never reach this register
   always_ff @(posedge mclk) begin
      if (srst) begin
         inonly_r <= `INONLY_RST;
      end else begin
         inonly_r <= inonlyPinIn & inputMask(inonlyPinModeHi, inonlyPinModeLo);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         serpin_r <= `SERPIN_RST;
      end else if (wrDone && hitSerpin) begin
         serpin_r <= pwdata[`SER_RW_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive, one cycle behind the register; no pull-up exists for the input-only port

   always_ff @(posedge mclk) begin
      if (srst) begin
         bidirPinOut <= `BIDIR_RST;
         bidirPinOe <= 8'h00;
         bidirPullUp <= 8'h00;
      end else begin
         bidirPinOut <= bidir_r;
         bidirPinOe <= modeMask(bidirPinModeHi, bidirPinModeLo, MODE_OUT);
         bidirPullUp <= modeMask(bidirPinModeHi, bidirPinModeLo, MODE_IN_PU);
      end
   end

   // eleven pads ride on eight bits: bit 7 never drives, rx bits yield to receive enable
   always_ff @(posedge mclk) begin
      if (srst) begin
         serpinOut <= 8'h00;
         serpinOe <= 8'h00;
         serpinPullUp <= 8'h00;
      end else begin
         serpinOut <= {1'b0, serpin_r};
         serpinOe <= modeMask(serpinModeHi, serpinModeLo, MODE_OUT) & ~serRxForce & 8'h7f;
         serpinPullUp <= modeMask(serpinModeHi, serpinModeLo, MODE_IN_PU);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic rdDone;
   assign rdDone = psel && penable && pready && !pwrite;

   property p_bidirStore;
      @(posedge mclk) disable iff (srst)
      wrDone && hitBidir |=> bidir_r == $past(pwdata[7:0]);
   endproperty
   a_bidirStore: assert property (p_bidirStore) else $error("bidir write not stored");

   property p_bidirRead;
      @(posedge mclk) disable iff (srst)
      setup && hitBidir && !pwrite ##1 rdDone |->
         prdata[7:0] == (($past(bidir_r) & ~$past(bidirIn)) | ($past(bidirPinIn) & $past(bidirIn)));
   endproperty
   a_bidirRead: assert property (p_bidirRead) else $error("bidir read value wrong");

   property p_bidirOe;
      @(posedge mclk) disable iff (srst)
      ##1 (bidirPinOe & ~$past(bidirPinModeLo & ~bidirPinModeHi)) == 8'h00;
   endproperty
   a_bidirOe: assert property (p_bidirOe) else $error("bidir pin driven outside output mode");

   property p_resetClear;
      @(posedge mclk) srst |=> bidir_r == 8'h00 && serpin_r == 7'h00 && inonly_r == 8'h00;
   endproperty
   a_resetClear: assert property (p_resetClear) else $error("registers not cleared by reset");

   property p_inonlyRead;
      @(posedge mclk) disable iff (srst)
      setup && hitInonly ##1 rdDone |-> (prdata[7:0] & ~$past(inputMask(inonlyPinModeHi, inonlyPinModeLo), 2)) == 8'h00;
   endproperty
   a_inonlyRead: assert property (p_inonlyRead) else $error("input-only bit not zero outside input");

   property p_upperZero;
      @(posedge mclk) disable iff (srst)
      pready |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upperZero: assert property (p_upperZero) else $error("upper read bits not zero");

   property p_ser7Low;
      @(posedge mclk) disable iff (srst)
      setup && hitSerpin && !pwrite && !serIn[7] ##1 rdDone |-> !prdata[7];
   endproperty
   a_ser7Low: assert property (p_ser7Low) else $error("serial bit 7 not low");

   property p_serStore;
      @(posedge mclk) disable iff (srst)
      wrDone && hitSerpin |=> serpin_r == $past(pwdata[6:0]) ##1 serpinOut[6:0] == $past(serpin_r);
   endproperty
   a_serStore: assert property (p_serStore) else $error("serial write not stored or driven");

   property p_rxInput;
      @(posedge mclk) disable iff (srst)
      receiveEnable |=> (serpinOe & 8'h15) == 8'h00 && !serpinOe[7];
   endproperty
   a_rxInput: assert property (p_rxInput) else $error("rx pin driven under receive enable");

   property p_serPull;
      @(posedge mclk) disable iff (srst)
      serpinModeHi[3] && !serpinModeLo[3] |=> serpinPullUp[3] ##0 !serpinOe[3];
   endproperty
   a_serPull: assert property (p_serPull) else $error("serial pull-up not on in mode 10");

   property p_serOe;
      @(posedge mclk) disable iff (srst)
      ##1 (serpinOe & ~$past(serpinModeLo & ~serpinModeHi)) == 8'h00;
   endproperty
   a_serOe: assert property (p_serOe) else $error("serial pin driven outside output mode");

   property p_bidirPinOut;
      @(posedge mclk) disable iff (srst)
      wrDone && hitBidir |=> ##1 bidirPinOut == $past(pwdata[7:0], 2);
   endproperty
   a_bidirPinOut: assert property (p_bidirPinOut) else $error("bidir write not on pin output");

   // hold checks use the sampled reset so the clearing edge itself is left out
   property p_bidirHold;
      @(posedge mclk)
      !srst && !(wrDone && hitBidir) |=> $stable(bidir_r);
   endproperty
   a_bidirHold: assert property (p_bidirHold) else $error("bidir register changed without write");

   property p_serHold;
      @(posedge mclk)
      !srst && !(wrDone && hitSerpin) |=> $stable(serpin_r);
   endproperty
   a_serHold: assert property (p_serHold) else $error("serial register changed without write");

   property p_inonlyZero;
      @(posedge mclk) disable iff (srst)
      ##1 (inonly_r & ~$past(inputMask(inonlyPinModeHi, inonlyPinModeLo))) == 8'h00;
   endproperty
   a_inonlyZero: assert property (p_inonlyZero) else $error("input-only bit set outside input");

   property p_rxRead;
      @(posedge mclk) disable iff (srst)
      setup && hitSerpin && !pwrite && receiveEnable ##1 rdDone |->
         (prdata[7:0] & `SER_RX_MASK) == ($past(serpinIn) & `SER_RX_MASK);
   endproperty
   a_rxRead: assert property (p_rxRead) else $error("rx pin level not read under receive enable");

   c_bidirWrite: cover property (@(posedge mclk) disable iff (srst) wrDone && hitBidir);
   c_inonlyWrite: cover property (@(posedge mclk) disable iff (srst) wrDone && hitInonly);
   c_bidirPinRead: cover property (@(posedge mclk) disable iff (srst) rdDone && hitBidir && (bidirIn != 8'h00));
   c_serRead: cover property (@(posedge mclk) disable iff (srst) rdDone && receiveEnable);
   c_badAddr: cover property (@(posedge mclk) disable iff (srst) pready && pslverr);

endmodule : gpio_kl_sc_ports
`default_nettype wire

// ### gpio_kl_sc_params.svh
// offsets, reset values and bit positions of the three data-register ports
// assumes inclusion by bare name from the package and the port module
`ifndef GPIO_KL_SC_PARAMS_SVH
`define GPIO_KL_SC_PARAMS_SVH

// printed register indices; the byte address on the bus is four times the index
`define BIDIR_IDX 32'h04000132
`define INONLY_IDX 32'h04000134
`define SERPIN_IDX 32'h04000136
`define BIDIR_ADDR (`BIDIR_IDX * 32'h4)
`define INONLY_ADDR (`INONLY_IDX * 32'h4)
`define SERPIN_ADDR (`SERPIN_IDX * 32'h4)

// power-on values
`define BIDIR_RST 8'h00
`define INONLY_RST 8'h00
`define SERPIN_RST 7'h00

// serial-pin port layout
`define SER_RO_BIT 7
`define SER_RW_MSB 6
`define SER_RX_MASK 8'h15
`define PORT_WIDTH 8

`endif

// ### gpio_kl_sc_pkg.sv
// types shared by the port data-register block
// assumes the params header is on the include path
`include "gpio_kl_sc_params.svh"

package gpio_kl_sc_pkg;
   typedef logic [`PORT_WIDTH-1:0] byte_t;
   // two-bit pin mode, hi bit first: alternate, output, input pull-up on, input pull-up off
   typedef enum logic [1:0] {
      MODE_ALT,
      MODE_OUT,
      MODE_IN_PU,
      MODE_IN_NOPU
   } pinMode_t;
endpackage : gpio_kl_sc_pkg

// ### gpio_kl_sc_pad_model.sv
// pad model for one 8-bit two-way port: resolves the wire from design and far side
// assumes the bench drives extVal/extDrv after rising edges
`timescale 1ns/10ps
`default_nettype none
module gpio_kl_sc_pad_model (
   // clock
   input wire logic mclk,
   // design side
   input wire gpio_kl_sc_pkg::byte_t pinOut,
   input wire gpio_kl_sc_pkg::byte_t pinOe,
   input wire gpio_kl_sc_pkg::byte_t pullUp,
   // far side
   input wire gpio_kl_sc_pkg::byte_t extVal,
   input wire gpio_kl_sc_pkg::byte_t extDrv,
   output gpio_kl_sc_pkg::byte_t pinLevel
);
   import gpio_kl_sc_pkg::*;
   byte_t floatPat_r;
   // a floating pad must not settle to a tidy value, so it toggles every cycle
   always_ff @(posedge mclk) begin
      floatPat_r <= (floatPat_r === 8'h55) ? 8'haa : 8'h55;
   end
   ////////////////////////////////////////////////////////////////////////////////
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrv & extVal) | (~pinOe & ~extDrv & pullUp)
      | (~pinOe & ~extDrv & ~pullUp & floatPat_r);
endmodule : gpio_kl_sc_pad_model
`default_nettype wire

// ### port_k_l_sc_data_regs_tb.sv
// bench for the three port data registers: apb master, pad models, directed tests
// assumes the design header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "gpio_kl_sc_params.svh"
module port_k_l_sc_data_regs_tb;
   import gpio_kl_sc_pkg::*;
   logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, receiveEnable = 0, pready, pslverr;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   byte_t mHi = 0, mLo = 0, inonlyPinIn = 8'h5a, extVal = 8'h3c, extDrv = 8'hff;
   byte_t bIn, bOut, bOe, bPu, sIn, sOut, sOe, sPu;
   int fail_count = 0, checks = 0;
   always #2 mclk = ~mclk;
   gpio_kl_sc_ports i_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bidirPinModeHi(mHi), .bidirPinModeLo(mLo), .inonlyPinModeHi(mHi), .inonlyPinModeLo(mLo),
      .serpinModeHi(mHi), .serpinModeLo(mLo), .receiveEnable(receiveEnable), .bidirPinIn(bIn),
      .bidirPinOut(bOut), .bidirPinOe(bOe), .bidirPullUp(bPu), .inonlyPinIn(inonlyPinIn),
      .serpinIn(sIn), .serpinOut(sOut), .serpinOe(sOe), .serpinPullUp(sPu));
   gpio_kl_sc_pad_model i_padB (.mclk(mclk), .pinOut(bOut), .pinOe(bOe), .pullUp(bPu),
      .extVal(extVal), .extDrv(extDrv), .pinLevel(bIn));
   gpio_kl_sc_pad_model i_padS (.mclk(mclk), .pinOut(sOut), .pinOe(sOe), .pullUp(sPu),
      .extVal(extVal), .extDrv(extDrv), .pinLevel(sIn));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // request held until pready is sampled high; read data taken at that edge
   task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      // a wait for pready ends when it is sampled high; a hang is left to the watchdog
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] rd;
      logic err;
      apb(1, a, d, rd, err);
      chk("write err", 0, err);
   endtask : wr
   task automatic rdChk(input string nm, input logic [31:0] a, e, input logic eErr = 0);
      logic [31:0] rd;
      logic err;
      apb(0, a, 0, rd, err);
      chk(nm, e, rd);
      chk({nm, " err"}, eErr, err);
   endtask : rdChk
   task automatic setModes(input logic [1:0] m);
      @(posedge mclk);
      mHi <= {8{m[1]}}; mLo <= {8{m[0]}};
      repeat (3) @(posedge mclk);
      #1;
   endtask : setModes
   task automatic readAll(input logic [7:0] b, i, s);
      rdChk("bidir", `BIDIR_ADDR, b);
      rdChk("inonly", `INONLY_ADDR, i);
      rdChk("serpin", `SERPIN_ADDR, s);
   endtask : readAll
   ////////////////////////////////////////////////////////////////////////////////
   task automatic testAltAndOut;
      readAll(8'h00, 8'h00, 8'h00);
      wr(`BIDIR_ADDR, 32'ha5);
      wr(`INONLY_ADDR, 32'hff);
      wr(`SERPIN_ADDR, 32'hff);
      readAll(8'ha5, 8'h00, 8'h7f);
      setModes(2'b01);
      readAll(8'ha5, 8'h00, 8'h7f);
      chk("bidirPinOut", 8'ha5, bOut);
      chk("bidirPinOe", 8'hff, bOe);
      chk("serpinOut", 8'h7f, sOut);
      chk("serpinOe", 8'h7f, sOe);
      @(posedge mclk);
      receiveEnable <= 1;
      setModes(2'b01);
      chk("serpinOe rx", 8'h6a, sOe);
      rdChk("serpin rx", `SERPIN_ADDR, 8'h7e);
      receiveEnable <= 0;
      $display("test alt/out done");
   endtask : testAltAndOut
   task automatic testInputs;
      setModes(2'b10);
      readAll(8'h3c, 8'h5a, 8'h3c);
      chk("bidirPullUp", 8'hff, bPu);
      chk("serpinPullUp", 8'hff, sPu);
      chk("bidirPinOe", 8'h00, bOe);
      extDrv <= 8'h00;
      readAll(8'hff, 8'h5a, 8'hff);
      extDrv <= 8'hff;
      setModes(2'b11);
      chk("serpinPullUp off", 8'h00, sPu);
      chk("bidirPullUp off", 8'h00, bPu);
      @(posedge mclk);
      inonlyPinIn <= 8'hc3;
      readAll(8'h3c, 8'hc3, 8'h3c);
      rdChk("unmapped", `BIDIR_ADDR + 32'h4, 0, 1);
      $display("test inputs done");
   endtask : testInputs
   task automatic testReset;
      setModes(2'b00);
      @(posedge mclk);
      srst <= 1;
      repeat (2) @(posedge mclk);
      srst <= 0;
      readAll(8'h00, 8'h00, 8'h00);
      $display("test reset done");
   endtask : testReset
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 0;
      testAltAndOut();
      testInputs();
      testReset();
      complete_run();
   end
   // the tests need well under 400 cycles; this cuts a hang short
   initial begin
      #20000;
      fail_count++;
      complete_run();
   end
endmodule : port_k_l_sc_data_regs_tb
`default_nettype wire
